// ### adc_host_conversion_sequencer_tb.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: default divider and settle parameters
// Notes: converter b answers slower than converter a
`timescale 1ns/10ps
module adc_host_conversion_sequencer_tb;
    logic mclk;
    logic rst_n;
    logic ce;
    logic req_valid;
    logic req_ready;
    ahcs_pkg::ahcs_req_t req;
    logic res_valid;
    ahcs_pkg::ahcs_res_t res;
    logic conv_clk;
    logic [2:0] addr [2];
    logic [1:0] ale, start, oe, hold_smp;
    wire [1:0] eoc;
    wire [7:0] dout [2];
    int n_mismatch = 0;
    int num_checks = 0;
    int n_st [2] = '{0, 0};
    int n_al [2] = '{0, 0};
    int n_hd [2] = '{0, 0};
    int n_skew = 0;
    int n_early = 0;
    logic [1:0] st_q = 2'h0, al_q = 2'h0, hd_q = 2'h0, eoc_q = 2'h3, pend = 2'h0;
    realtime t_cc = 0.0, per_cc = 0.0;
    ahcs_sequencer uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res),
        .conv_clk(conv_clk), .addr(addr), .ale(ale), .start(start), .oe(oe),
        .hold_smp(hold_smp), .eoc(eoc), .dout(dout));
    ahcs_conv_model #(.BASE(8'h20), .LAST(7'h3f)) conv_a (.conv_clk(conv_clk),
        .addr(addr[0]), .ale(ale[0]), .start(start[0]), .oe(oe[0]), .eoc(eoc[0]),
        .dout(dout[0]));
    ahcs_conv_model #(.BASE(8'h80), .LAST(7'h4f)) conv_b (.conv_clk(conv_clk),
        .addr(addr[1]), .ale(ale[1]), .start(start[1]), .oe(oe[1]), .eoc(eoc[1]),
        .dout(dout[1]));
    // ***********************************
    // clock and pin monitors
    // ***********************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge conv_clk) begin
        per_cc = $realtime - t_cc;
        t_cc = $realtime;
    end
    always @(negedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            if (start[i] && !st_q[i]) begin
                n_st[i]++;
                if (pend[i])
                    n_early++;
            end
            if (ale[i] && !al_q[i])
                n_al[i]++;
            if (hold_smp[i] && !hd_q[i])
                n_hd[i]++;
            if (eoc[i] && !eoc_q[i])
                pend[i] = 1'b1;
            if (oe[i])
                pend[i] = 1'b0;
        end
        if (start[0] !== start[1])
            n_skew++;
        st_q = start;
        al_q = ale;
        hd_q = hold_smp;
        eoc_q = eoc;
    end
    // ***********************************
    // shared tasks
    // ***********************************
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] cv(input logic [7:0] base, input logic [2:0] ch);
        return base + 8'(ch) * 8'h0b;
    endfunction : cv
    task automatic run(input ahcs_pkg::ahcs_op_t op, input ahcs_pkg::ahcs_mode_t md,
        input logic [2:0] a, input logic [2:0] b);
        int k;
        @(negedge mclk);
        check(16'(req_ready), 16'h1);
        req = '{op: op, mode: md, chan_a: a, chan_b: b};
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        k = 0;
        while (res_valid !== 1'b1 && k < 8000) begin
            @(negedge mclk);
            k++;
        end
        if (k == 8000) begin
            n_mismatch++;
            final_report();
        end
    endtask : run
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_modes();
        ahcs_pkg::ahcs_mode_t md [3] = '{ahcs_pkg::AHCS_MODE_TIED,
            ahcs_pkg::AHCS_MODE_SPLIT, ahcs_pkg::AHCS_MODE_DOUBLE};
        int al_e [3] = '{2, 1, 2};
        int st_e [3] = '{2, 1, 2};
        int s0, a0;
        for (int m = 0; m < 3; m++) begin
            s0 = n_st[0];
            a0 = n_al[0];
            run(ahcs_pkg::AHCS_OP_SINGLE, md[m], 3'(m * 3 + 1), 3'h0);
            check(16'(res.data_a), 16'(cv(8'h20, 3'(m * 3 + 1))));
            check(16'(n_al[0] - a0), 16'(al_e[m]));
            check(16'(n_st[0] - s0), 16'(st_e[m]));
        end
    endtask : t_modes
    task automatic t_diff();
        run(ahcs_pkg::AHCS_OP_DIFF, ahcs_pkg::AHCS_MODE_DOUBLE, 3'h0, 3'h6);
        check(16'(res.data_a), 16'(cv(8'h20, 3'h0)));
        check(16'(res.data_b), 16'(cv(8'h20, 3'h6)));
        check(16'(res.diff), 16'(9'({1'b0, cv(8'h20, 3'h0)} - {1'b0, cv(8'h20, 3'h6)})));
    endtask : t_diff
    task automatic t_dual();
        n_skew = 0;
        run(ahcs_pkg::AHCS_OP_DUAL, ahcs_pkg::AHCS_MODE_TIED, 3'h2, 3'h5);
        check(16'(eoc), 16'h3);
        check(16'(n_skew), 16'h0);
        check(16'(res.data_a), 16'(cv(8'h20, 3'h2)));
        check(16'(res.data_b), 16'(cv(8'h80, 3'h5)));
    endtask : t_dual
    task automatic t_alt();
        int s [2] = n_st;
        int h = n_hd[0] + n_hd[1];
        int d1a, d1b, d2a;
        run(ahcs_pkg::AHCS_OP_ALT, ahcs_pkg::AHCS_MODE_SPLIT, 3'h3, 3'h0);
        check(16'(res.data_a), 16'(cv(8'h20, 3'h3)));
        d1a = n_st[0] - s[0];
        d1b = n_st[1] - s[1];
        check(16'(n_hd[0] + n_hd[1] - h), 16'h1);
        run(ahcs_pkg::AHCS_OP_ALT, ahcs_pkg::AHCS_MODE_SPLIT, 3'h6, 3'h0);
        check(16'(res.data_a), 16'(cv(8'h80, 3'h6)));
        d2a = n_st[0] - s[0] - d1a;
        check(16'((d1a == 0) ^ (d1b == 0)), 16'h1);
        check(16'((d1a == 0) ^ (d2a == 0)), 16'h1);
        check(16'(n_hd[0] + n_hd[1] - h), 16'h2);
    endtask : t_alt
    task automatic t_ce();
        logic c0;
        @(negedge mclk);
        ce = 1'b0;
        c0 = conv_clk;
        repeat (20) @(negedge mclk);
        check(16'(conv_clk), 16'(c0));
        ce = 1'b1;
    endtask : t_ce
    task automatic t_clk();
        check(16'(int'(per_cc)), 16'h0640);
        check(16'(n_early), 16'h0);
    endtask : t_clk
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_modes();
        t_diff();
        t_dual();
        t_alt();
        t_ce();
        t_clk();
        final_report();
    end
endmodule : adc_host_conversion_sequencer_tb

// ### ahcs_conv_model.sv
// Purpose: behavioural eight-channel converter on the far side of the host
// Assumes: clocked by the host's divided converter clock; ale and start act on their own edges
// Notes: no reset pin, so state starts from declared values
`timescale 1ns/10ps
module ahcs_conv_model #(
    parameter logic [7:0] BASE = 8'h20,
    parameter logic [6:0] LAST = 7'h3f
) (
    // pins from the host
    input wire logic conv_clk,
    input wire logic [2:0] addr,
    input wire logic ale,
    input wire logic start,
    input wire logic oe,
    // pins to the host
    output logic eoc,
    output logic [7:0] dout
);
    logic [2:0] mux_r = 3'h0;
    logic [2:0] ph_r = 3'h0;
    logic [6:0] cnt_r = 7'h0;
    logic arm_r = 1'b0;
    logic st_tog = 1'b0;
    logic st_ack = 1'b0;
    logic busy_r = 1'b0;
    logic [7:0] smp_r = 8'h0;
    logic [7:0] out_r = 8'h0;
    realtime t_mux = 0.0;
    initial eoc = 1'b1;
    // ***********************************
    // address latch
    // ***********************************
    always @(posedge ale) begin
        // same address again keeps the settled input
        if (addr !== mux_r)
            t_mux = $realtime;
        mux_r = addr;
    end
    // ***********************************
    // conversion, free-running 8-clock cycle
    // ***********************************
    // start acts on its own edge, so a pulse shorter than a clock still counts
    always @(posedge start) begin
        st_tog = ~st_tog;
    end
    always @(posedge conv_clk) begin
        ph_r <= ph_r + 3'h1;
        if (st_tog != st_ack) begin
            st_ack <= st_tog;
            arm_r <= 1'b1;
            busy_r <= 1'b0;
        end
        if (ph_r == 3'h7 && (arm_r || st_tog != st_ack))
            eoc <= 1'b0;
        if (ph_r == 3'h7 && arm_r && !start && st_tog == st_ack) begin
            busy_r <= 1'b1;
            arm_r <= 1'b0;
            cnt_r <= 7'h0;
            // unsettled input reads full scale, no kinder than silicon
            smp_r <= ($realtime - t_mux < 3000.0) ? 8'hff : BASE + 8'(mux_r) * 8'h0b;
        end
        if (busy_r && !start)
            cnt_r <= cnt_r + 7'h1; // LAST + 1 clocks, eight samples of eight at the default LAST
        if (busy_r && !start && cnt_r == LAST) begin
            busy_r <= 1'b0;
            out_r <= smp_r;
            eoc <= 1'b1;
        end
    end
    // released outputs show the inverse so a late read is caught
    assign dout = oe ? out_r : ~out_r;
endmodule : ahcs_conv_model

// ### ahcs_pkg.sv
// Purpose: constants and carriers for the converter conversion sequencer
// Assumes: 10 MHz system clock
// Notes: converter clock is made here by division, so it is no second domain
package ahcs_pkg;
    // ***********************************
    // timing
    // ***********************************
    localparam int unsigned MCLK_KHZ = 10000;
    localparam int unsigned CONV_CLK_MAX_KHZ = 1200;
    localparam int unsigned SLOW_CLK_KHZ = 500;
    localparam int unsigned SETTLE_NS = 3000;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS * MCLK_KHZ + 999999) / 1000000;
    localparam int unsigned CONV_DIV_MIN = (MCLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
    localparam int unsigned CONV_DIV_DEF = 16;
    localparam int unsigned STRB_CYC = 4;
    localparam int unsigned EOC_LOW_WAIT = 400;
    localparam int unsigned OE_CYC = 4;
    // ***********************************
    // modes
    // ***********************************
    typedef enum logic [1:0] {
        AHCS_MODE_TIED = 2'h0,
        AHCS_MODE_SPLIT = 2'h1,
        AHCS_MODE_DOUBLE = 2'h2
    } ahcs_mode_t;
    typedef enum logic [1:0] {
        AHCS_OP_SINGLE = 2'h0,
        AHCS_OP_DIFF = 2'h1,
        AHCS_OP_DUAL = 2'h2,
        AHCS_OP_ALT = 2'h3
    } ahcs_op_t;
    typedef struct packed {
        ahcs_op_t op;
        ahcs_mode_t mode;
        logic [2:0] chan_a;
        logic [2:0] chan_b;
    } ahcs_req_t;
    typedef struct packed {
        logic [7:0] data_a;
        logic [7:0] data_b;
        logic [8:0] diff;
    } ahcs_res_t;
endpackage : ahcs_pkg

// ### ahcs_sequencer.sv
// Purpose: host sequencer driving two eight-channel converters
// Assumes: converter pins are asynchronous to mclk; eoc/data synchronised
// Notes: converter clock derived by a divider from mclk
`timescale 1ns/10ps
module ahcs_sequencer #(
    parameter int unsigned CONV_DIV = ahcs_pkg::CONV_DIV_DEF,
    parameter int unsigned SETTLE = ahcs_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // request side
    input wire logic req_valid,
    output logic req_ready,
    input wire ahcs_pkg::ahcs_req_t req,
    output logic res_valid,
    output ahcs_pkg::ahcs_res_t res,
    // converter pins, index 0 is converter a
    output logic conv_clk,
    output logic [2:0] addr [2],
    output logic [1:0] ale,
    output logic [1:0] start,
    output logic [1:0] oe,
    output logic [1:0] hold_smp,
    input wire logic [1:0] eoc,
    input wire logic [7:0] dout [2]
);
    typedef enum logic [3:0] {
        S_IDLE, S_LATCH, S_SETTLE, S_START, S_EOCLOW, S_EOCHIGH, S_READ,
        S_HOLD, S_DONE
    } ahcs_st_t;
    // odd or too small ratios round up, never faster than the limit
    localparam int unsigned DIV_USE = (CONV_DIV < ahcs_pkg::CONV_DIV_MIN) ?
        ahcs_pkg::CONV_DIV_MIN : CONV_DIV;
    localparam int unsigned DIVH = (DIV_USE + 1) / 2;
    localparam int unsigned CONV_KHZ = ahcs_pkg::MCLK_KHZ / (DIVH * 2);
    localparam logic FAST = CONV_KHZ > ahcs_pkg::SLOW_CLK_KHZ;

    ahcs_st_t st_r;
    ahcs_pkg::ahcs_req_t q_r;
    logic [15:0] cnt_r;
    logic [7:0] div_r;
    logic clk_r;
    logic [1:0] eoc_s1_r, eoc_s2_r;
    logic [7:0] d_s1_r [2];
    logic [7:0] d_s2_r [2];
    logic sel_r;      // which converter this pass uses
    logic second_r;   // second pass (diff b channel)
    logic alt_r;      // alternate converter toggle
    logic strobe_r, latch_r, oe_r, smp_r;

    function automatic logic [1:0] uses(input ahcs_pkg::ahcs_op_t op, input logic s);
        uses = (op == ahcs_pkg::AHCS_OP_DUAL) ? 2'h3 : (s ? 2'h2 : 2'h1);
    endfunction : uses

    // ***********************************
    // converter clock divider
    // ***********************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
            clk_r <= 1'b0;
        end else if (ce) begin
            if (div_r == 8'(DIVH - 1)) begin
                div_r <= 8'h00;
                clk_r <= ~clk_r;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end
    assign conv_clk = clk_r;

    // ***********************************
    // pin synchronisers
    // ***********************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eoc_s1_r <= 2'h0;
            eoc_s2_r <= 2'h0;
            d_s1_r <= '{8'h00, 8'h00};
            d_s2_r <= '{8'h00, 8'h00};
        end else if (ce) begin
            eoc_s1_r <= eoc;
            eoc_s2_r <= eoc_s1_r;
            d_s1_r <= dout;
            d_s2_r <= d_s1_r;
        end
    end

    // ***********************************
    // sequencer
    // ***********************************
    logic [1:0] u;
    logic eoc_all, eoc_none, last;
    assign u = uses(q_r.op, sel_r);
    assign eoc_all = &(eoc_s2_r | ~u);
    assign eoc_none = ~|(eoc_s2_r & u);
    assign last = (q_r.op != ahcs_pkg::AHCS_OP_DIFF) || second_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            q_r <= '0;
            cnt_r <= 16'h0000;
            sel_r <= 1'b0;
            second_r <= 1'b0;
            alt_r <= 1'b0;
            strobe_r <= 1'b0;
            latch_r <= 1'b0;
            oe_r <= 1'b0;
            smp_r <= 1'b0;
            res_valid <= 1'b0;
            res <= '0;
        end else if (ce) begin
            res_valid <= 1'b0;
            cnt_r <= cnt_r + 16'h0001;
            case (st_r)
                S_IDLE: begin
                    if (req_valid) begin
                        q_r <= req;
                        cnt_r <= 16'h0000;
                        second_r <= 1'b0;
                        sel_r <= (req.op == ahcs_pkg::AHCS_OP_ALT) ? alt_r : 1'b0;
                        if (req.op == ahcs_pkg::AHCS_OP_ALT) begin
                            alt_r <= ~alt_r;
                            smp_r <= 1'b1;
                            st_r <= S_HOLD;
                        end else begin
                            st_r <= S_LATCH;
                        end
                    end
                end
                S_HOLD: begin
                    if (smp_r && cnt_r == 16'(ahcs_pkg::STRB_CYC - 1)) begin
                        smp_r <= 1'b0;
                        cnt_r <= 16'h0000;
                    end
                    if (!smp_r && cnt_r == 16'(SETTLE - 1)) begin
                        cnt_r <= 16'h0000;
                        st_r <= S_LATCH;   // hold done, then convert
                    end
                end
                S_LATCH: begin
                    // tied and double modes strobe start with the latch
                    latch_r <= 1'b1;
                    strobe_r <= (q_r.mode != ahcs_pkg::AHCS_MODE_SPLIT);
                    if (cnt_r == 16'(ahcs_pkg::STRB_CYC)) begin
                        latch_r <= 1'b0;
                        strobe_r <= 1'b0;
                        cnt_r <= 16'h0000;
                        if (q_r.mode == ahcs_pkg::AHCS_MODE_TIED && !FAST)
                            st_r <= S_EOCLOW;  // slow clock absorbs settle
                        else
                            st_r <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (cnt_r == 16'(SETTLE - 1)) begin
                        cnt_r <= 16'h0000;
                        st_r <= S_START;
                    end
                end
                S_START: begin
                    // split: start alone double: same address again
                    // a tied line cannot start without latching, so it repeats too
                    strobe_r <= 1'b1;
                    latch_r <= (q_r.mode != ahcs_pkg::AHCS_MODE_SPLIT);
                    if (cnt_r == 16'(ahcs_pkg::STRB_CYC)) begin
                        strobe_r <= 1'b0;
                        latch_r <= 1'b0;
                        cnt_r <= 16'h0000;
                        st_r <= S_EOCLOW;
                    end
                end
                S_EOCLOW: begin
                    // end flag drops within 8 converter clocks of start
                    if (eoc_none || cnt_r == 16'(ahcs_pkg::EOC_LOW_WAIT)) begin
                        st_r <= S_EOCHIGH;
                    end
                end
                S_EOCHIGH: begin
                    if (eoc_all && eoc_none == 1'b0) begin
                        oe_r <= 1'b1;
                        cnt_r <= 16'h0000;
                        st_r <= S_READ;
                    end
                end
                S_READ: begin
                    if (cnt_r == 16'(ahcs_pkg::OE_CYC)) begin
                        oe_r <= 1'b0;
                        cnt_r <= 16'h0000;
                        if (q_r.op == ahcs_pkg::AHCS_OP_DIFF && second_r) begin
                            res.data_b <= d_s2_r[0];
                            res.diff <= {1'b0, res.data_a} - {1'b0, d_s2_r[0]};
                        end else if (q_r.op == ahcs_pkg::AHCS_OP_DUAL) begin
                            res.data_a <= d_s2_r[0];
                            res.data_b <= d_s2_r[1];
                            res.diff <= {1'b0, d_s2_r[0]} - {1'b0, d_s2_r[1]};
                        end else begin
                            res.data_a <= d_s2_r[sel_r];
                            res.data_b <= 8'h00;
                            res.diff <= 9'h000;
                        end
                        // read done before any new start
                        if (last) begin
                            st_r <= S_DONE;
                        end else begin
                            second_r <= 1'b1;
                            st_r <= S_LATCH;
                        end
                    end
                end
                S_DONE: begin
                    res_valid <= 1'b1;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ***********************************
    // pin drive
    // ***********************************
    logic [2:0] cur_ch;
    assign cur_ch = second_r && q_r.op == ahcs_pkg::AHCS_OP_DIFF ? q_r.chan_b : q_r.chan_a;
    assign req_ready = (st_r == S_IDLE);
    assign addr[0] = (q_r.op == ahcs_pkg::AHCS_OP_DUAL) ? q_r.chan_a : cur_ch;
    assign addr[1] = (q_r.op == ahcs_pkg::AHCS_OP_DUAL) ? q_r.chan_b : cur_ch;
    assign ale = latch_r ? u : 2'h0;
    assign start = strobe_r ? u : 2'h0;  // both at once in dual
    assign oe = oe_r ? u : 2'h0;
    assign hold_smp = smp_r ? u : 2'h0;

    // ***********************************
    // checks
    // ***********************************
    a_start_ready_read: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(|start) |-> $past(st_r) != S_READ || !$past(oe_r)) else $error("start during read");
    a_oe_after_eoc: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(oe_r) |-> $past(eoc_all)) else $error("oe before end flag");
    a_dual_both_start: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.op == ahcs_pkg::AHCS_OP_DUAL && |start) |-> start == 2'h3) else $error("dual skew");
    a_settle_gap: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        (st_r == S_SETTLE && $past(st_r) == S_LATCH) |-> (!(|start))[*8]) else $error("no settle");
    a_tied_same: assert property (@(posedge mclk) disable iff (!rst_n)
        q_r.mode != ahcs_pkg::AHCS_MODE_SPLIT |-> ale == start) else $error("tied strobes differ");
    a_split_latch_only: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.mode == ahcs_pkg::AHCS_MODE_SPLIT && st_r == S_LATCH) |-> start == 2'h0)
        else $error("split start early");
    a_double_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        (q_r.mode == ahcs_pkg::AHCS_MODE_DOUBLE && st_r == S_START && strobe_r) |->
        ale == start && $stable(addr[0])) else $error("double strobe bad");
    a_hold_before_conv: assert property (@(posedge mclk) disable iff (!rst_n)
        |hold_smp |-> !(|start) && !(|ale)) else $error("sample overlaps start");
    a_clk_div_half: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        $changed(clk_r) |=> !$changed(clk_r)) else $error("clock too fast");
    c_single: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r == S_DONE && q_r.op == ahcs_pkg::AHCS_OP_SINGLE);
    c_diff: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r == S_DONE && q_r.op == ahcs_pkg::AHCS_OP_DIFF);
    c_dual: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r == S_DONE && q_r.op == ahcs_pkg::AHCS_OP_DUAL);
    c_alt: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r == S_DONE && q_r.op == ahcs_pkg::AHCS_OP_ALT);
endmodule : ahcs_sequencer
